// file: rtl/sas_device.sv
// Operation
// - chip-select fall holds sample, starts conversion
// - conversion timed internally, done within 8.5us
// - output driven low while converting
// - output goes high when conversion ends
// - master keeps serial clock idle while converting
// - result latched into shift register for readout
// - output changes on clock falls, MSB first
// - master gives at least 13 falling edges
// - surplus clocks shift zeros, harmless
// - master clock up to 5MHz, phases 100ns
// - unsigned code after one high flag bit
// - low power-down input means shutdown
// - driven high selects internal reference
// - master waits wake delay before starting
// - master allows 20ms reference charge time
// - master waits acquisition time between conversions
// - output released while chip select high
// - after abort master waits acquisition time
// - master uses clock polarity 0, phase 0
`timescale 1ns/1ps
`default_nettype none
module sas_device #(
  parameter bit INT_REF_VARIANT = 1'b1
) (
  input  wire logic                       clk_sys,
  input  wire logic                       rst,
  input  wire logic                       ce,
  sas_link_if.dev                         link,
  input  wire logic [sas_pkg::RES_W-1:0]  analogInput,
  output logic      [sas_pkg::RES_W-1:0]  resultCode,
  output logic                            resultValid,
  output logic                            busy,
  output logic                            holding,
  output logic                            shutdown,
  output logic                            internalRef,
  output logic                            awake,
  output logic                            startRefused,
  output logic                            clkViolation,
  output logic                            readoutDone
);
  import sas_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  sas_dev_s q;
  sas_dev_s d;
  logic     csHigh;
  logic     csFall;
  logic     sclkFall;
  logic     pdHigh;
  logic     pdFloat;

  // edges come from the second stage and its delayed copy only
  // so a pin change acts on the third clock edge after it
  assign csHigh   = q.sync[IN_CS];
  assign csFall   = q.prev[IN_CS] & ~q.sync[IN_CS];
  assign sclkFall = q.prev[IN_SCLK] & ~q.sync[IN_SCLK];
  assign pdHigh   = q.sync[IN_PD];
  assign pdFloat  = q.sync[IN_FLT];

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    d = q;
    d.meta = {link.pdFloat, link.pdLevel, link.sclk, link.csN};
    d.sync = q.meta;
    d.prev = q.sync;
    d.resultValid  = 1'b0;
    d.startRefused = 1'b0;
    d.clkViolation = 1'b0;
    d.readoutDone  = 1'b0;
    d.shutdown     = ~pdHigh;
    // reference choice only exists on the internal-reference part
    d.internalRef  = INT_REF_VARIANT & pdHigh & ~pdFloat;

    // wake delay is tracked so an early start can be flagged
    // awake is preset at reset: the part is taken as long powered
    if (!pdHigh) begin
      d.wakeCnt = 8'h00;
      d.awake   = 1'b0;
    end else if (!q.awake) begin
      if (q.wakeCnt == 8'(WAKE_CYC - 1)) begin
        d.awake = 1'b1;
      end else begin
        d.wakeCnt = q.wakeCnt + 8'h01;
      end
    end

    unique case (q.state)
      DEV_OFF: begin
        d.doutOe  = 1'b0;
        d.busy    = 1'b0;
        d.holding = 1'b0;
        if (pdHigh) begin
          d.state = DEV_IDLE;
        end
      end

      DEV_IDLE: begin
        d.doutOe  = 1'b0;
        d.holding = 1'b0;
        d.busy    = 1'b0;
        if (csFall) begin
          // a start inside the wake delay is refused, never queued
          if (!q.awake) begin
            d.startRefused = 1'b1;
          end else begin
            d.state   = DEV_CONV;
            d.held    = analogInput;
            d.holding = 1'b1;
            d.busy    = 1'b1;
            d.timer   = 10'h000;
            d.doutOe  = 1'b1;
            d.doutO   = 1'b0;
          end
        end
      end

      DEV_CONV: begin
        // a clock during conversion is only flagged; it cannot corrupt
        if (sclkFall) begin
          d.clkViolation = 1'b1;
        end
        if (csHigh) begin
          // abort: sample and result are dropped
          d.state   = DEV_IDLE;
          d.doutOe  = 1'b0;
          d.holding = 1'b0;
          d.busy    = 1'b0;
        end else if (q.timer == 10'(CONV_CYC - 1)) begin
          d.state   = DEV_SEND;
          d.shreg   = q.held;
          d.result  = q.held;
          d.resultValid = 1'b1;
          d.bitCnt  = 4'h0;
          d.doutO   = 1'b1;
          d.holding = 1'b0;
          d.busy    = 1'b0;
        end else begin
          d.timer = q.timer + 10'h001;
        end
      end

      DEV_SEND: begin
        if (csHigh) begin
          d.state  = DEV_IDLE;
          d.doutOe = 1'b0;
        end else if (sclkFall) begin
          // bit after the flag is the MSB; zeros fill in behind
          d.doutO = q.shreg[RES_W-1];
          d.shreg = {q.shreg[RES_W-2:0], 1'b0};
          // the count parks at RES_W so surplus clocks never wrap it
          if (q.bitCnt != 4'(RES_W)) begin
            d.bitCnt = q.bitCnt + 4'h1;
            if (q.bitCnt == 4'(RES_W - 1)) begin
              d.readoutDone = 1'b1;
            end
          end
        end
      end

      default: begin
        // a corrupted state code falls back to a released idle
        d.state  = DEV_IDLE;
        d.doutOe = 1'b0;
      end
    endcase

    // shutdown overrides state, busy, holding and output enable; any frame is lost
    if (!pdHigh) begin
      d.state   = DEV_OFF;
      d.doutOe  = 1'b0;
      d.busy    = 1'b0;
      d.holding = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  // ce low freezes every field, synchronisers included
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      q <= DEV_RST;
    end else if (ce) begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // every output is a flop, so the pins never see next-state glitches
  assign link.doutO   = q.doutO;
  assign link.doutOe  = q.doutOe;
  assign resultCode   = q.result;
  assign resultValid  = q.resultValid;
  assign busy         = q.busy;
  assign holding      = q.holding;
  assign shutdown     = q.shutdown;
  assign internalRef  = q.internalRef;
  assign awake        = q.awake;
  assign startRefused = q.startRefused;
  assign clkViolation = q.clkViolation;
  assign readoutDone  = q.readoutDone;
endmodule
`default_nettype wire

// file: rtl/sas_pkg.sv
package sas_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 10000;

  function automatic int ceilCyc(int ns);
    ceilCyc = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    if (ceilCyc < 1) ceilCyc = 1;
  endfunction

  function automatic int floorCyc(int ns);
    floorCyc = (ns * 1000) / CLK_PERIOD_PS;
    if (floorCyc < 1) floorCyc = 1;
  endfunction

  localparam int CONV_TIME_NS  = 8500;
  localparam int ACQ_TIME_NS   = 1500;
  localparam int WAKE_TIME_NS  = 2000;
  localparam int SCLK_PHASE_NS = 100;
  localparam int OUT_EN_NS     = 100;
  localparam int PWRUP_TIME_MS = 20;

  localparam int CONV_CYC     = floorCyc(CONV_TIME_NS);
  localparam int ACQ_CYC      = ceilCyc(ACQ_TIME_NS);
  localparam int WAKE_CYC     = ceilCyc(WAKE_TIME_NS);
  localparam int HALF_CYC     = ceilCyc(SCLK_PHASE_NS);
  localparam int OUT_EN_CYC   = ceilCyc(OUT_EN_NS);
  localparam int CONV_MARGIN  = 16;
  localparam int CONV_TMO_CYC = CONV_CYC + CONV_MARGIN;
  localparam int PWRUP_CYC    = PWRUP_TIME_MS * 100000;

  // ---------------------------------------------------------------
  // frame layout
  // ---------------------------------------------------------------
  localparam int RES_W       = 12;
  localparam int FRAME_EDGES = 13;
  localparam int FIFO_DEPTH  = 8;

  // synchroniser lanes of the device
  localparam int IN_CS   = 0;
  localparam int IN_SCLK = 1;
  localparam int IN_PD   = 2;
  localparam int IN_FLT  = 3;

  // ---------------------------------------------------------------
  // device state
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    DEV_OFF  = 4'h1,
    DEV_IDLE = 4'h2,
    DEV_CONV = 4'h4,
    DEV_SEND = 4'h8
  } sas_dev_state_e;

  typedef struct packed {
    logic [3:0]       meta;
    logic [3:0]       sync;
    logic [3:0]       prev;
    sas_dev_state_e   state;
    logic [9:0]       timer;
    logic [7:0]       wakeCnt;
    logic             awake;
    logic [RES_W-1:0] held;
    logic [RES_W-1:0] shreg;
    logic [3:0]       bitCnt;
    logic             doutO;
    logic             doutOe;
    logic [RES_W-1:0] result;
    logic             resultValid;
    logic             busy;
    logic             holding;
    logic             shutdown;
    logic             internalRef;
    logic             startRefused;
    logic             clkViolation;
    logic             readoutDone;
  } sas_dev_s;

  // pin lanes reset to their idle levels, so no false edge follows reset
  localparam sas_dev_s DEV_RST = '{
    meta: 4'hD, sync: 4'hD, prev: 4'hD, state: DEV_IDLE,
    timer: 10'h000, wakeCnt: 8'h00, awake: 1'b1,
    held: 12'h000, shreg: 12'h000, bitCnt: 4'h0,
    doutO: 1'b0, doutOe: 1'b0, result: 12'h000,
    resultValid: 1'b0, busy: 1'b0, holding: 1'b0,
    shutdown: 1'b0, internalRef: 1'b0, startRefused: 1'b0,
    clkViolation: 1'b0, readoutDone: 1'b0};

  // ---------------------------------------------------------------
  // host state
  // ---------------------------------------------------------------
  typedef enum logic [6:0] {
    HST_PWRUP = 7'h01,
    HST_DOWN  = 7'h02,
    HST_WAKE  = 7'h04,
    HST_ACQ   = 7'h08,
    HST_CONV  = 7'h10,
    HST_SHIFT = 7'h20,
    HST_STORE = 7'h40
  } sas_host_state_e;

  typedef struct packed {
    logic             meta;
    logic             sync;
    sas_host_state_e  state;
    logic [21:0]      cnt;
    logic [3:0]       halfCnt;
    logic [3:0]       edgeCnt;
    logic [12:0]      shift;
    logic             csN;
    logic             sclk;
    logic             pdO;
    logic             pdOe;
    logic             pushValid;
    logic             busy;
    logic             linkReady;
    logic             timeoutPulse;
    logic             frameErr;
  } sas_host_s;

  localparam sas_host_s HOST_RST = '{
    meta: 1'b1, sync: 1'b1, state: HST_PWRUP, cnt: 22'h000000,
    halfCnt: 4'h0, edgeCnt: 4'h0, shift: 13'h0000, csN: 1'b1,
    sclk: 1'b0, pdO: 1'b1, pdOe: 1'b0, pushValid: 1'b0,
    busy: 1'b0, linkReady: 1'b0, timeoutPulse: 1'b0,
    frameErr: 1'b0};

  typedef struct packed {
    logic [2:0] rdPtr;
    logic [2:0] wrPtr;
    logic [3:0] count;
  } sas_fifo_s;

  localparam sas_fifo_s FIFO_RST = '{3'h0, 3'h0, 4'h0};

endpackage

// file: rtl/sas_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sas_link_if;
  logic csN;
  logic sclk;
  logic doutO;
  logic doutOe;
  logic pdO;
  logic pdOe;
  logic doutLevel;
  logic pdLevel;
  logic pdFloat;

  // undriven lines read high, as through a pull-up
  assign doutLevel = doutOe ? doutO : 1'b1;
  assign pdLevel   = pdOe ? pdO : 1'b1;
  assign pdFloat   = ~pdOe;

  modport dev (
    input  csN,
    input  sclk,
    input  pdLevel,
    input  pdFloat,
    output doutO,
    output doutOe
  );

  modport host (
    output csN,
    output sclk,
    output pdO,
    output pdOe,
    input  doutLevel
  );
endinterface
`default_nettype wire

// file: rtl/sas_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module sas_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  import sas_pkg::*;

  logic [WIDTH-1:0] mem [DEPTH];
  sas_fifo_s        q;
  sas_fifo_s        d;
  logic             doPush;
  logic             doPop;

  assign inReady  = (q.count != 4'(DEPTH));
  assign outValid = (q.count != 4'h0);
  assign outData  = mem[q.rdPtr];
  assign doPush   = inValid & inReady;
  assign doPop    = outValid & outReady;

  always_comb begin
    d = q;
    if (doPush) begin
      d.wrPtr = q.wrPtr + 3'h1;
    end
    if (doPop) begin
      d.rdPtr = q.rdPtr + 3'h1;
    end
    d.count = q.count + {3'h0, doPush} - {3'h0, doPop};
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      q <= FIFO_RST;
    end else if (ce) begin
      q <= d;
      if (doPush) begin
        mem[q.wrPtr] <= inData;
      end
    end
  end
endmodule
`default_nettype wire

// file: rtl/sas_host.sv
`timescale 1ns/1ps
`default_nettype none
module sas_host #(
  parameter int PWRUP_WAIT = sas_pkg::PWRUP_CYC
) (
  input  wire logic                       clk_sys,
  input  wire logic                       rst,
  input  wire logic                       ce,
  sas_link_if.host                        link,
  input  wire logic                       runEnable,
  input  wire logic                       shutdownReq,
  input  wire logic                       useIntRef,
  output logic      [sas_pkg::RES_W-1:0]  outData,
  output logic                            outValid,
  input  wire logic                       outReady,
  output logic                            busy,
  output logic                            linkReady,
  output logic                            timeoutPulse,
  output logic                            frameErr
);
  import sas_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  sas_host_s q;
  sas_host_s d;
  logic      fifoReady;

  always_comb begin
    d = q;
    d.meta = link.doutLevel;
    d.sync = q.meta;
    d.timeoutPulse = 1'b0;
    d.frameErr     = 1'b0;
    d.cnt = q.cnt + 22'h000001;

    unique case (q.state)
      HST_PWRUP: begin
        if (q.cnt >= 22'(PWRUP_WAIT - 1)) begin
          d.state     = HST_ACQ;
          d.cnt       = 22'h000000;
          d.linkReady = 1'b1;
        end
      end

      HST_DOWN: begin
        if (!shutdownReq) begin
          d.state = HST_WAKE;
          d.cnt   = 22'h000000;
        end
      end

      HST_WAKE: begin
        if (q.cnt >= 22'(WAKE_CYC - 1)) begin
          d.state = HST_ACQ;
          d.cnt   = 22'h000000;
        end
      end

      HST_ACQ: begin
        d.csN  = 1'b1;
        d.busy = 1'b0;
        if (shutdownReq) begin
          d.state = HST_DOWN;
        end else if (q.cnt >= 22'(ACQ_CYC - 1)) begin
          d.cnt = q.cnt;
          // no start without room, so a stalled drain holds the link
          if (runEnable && fifoReady) begin
            d.state = HST_CONV;
            d.csN   = 1'b0;
            d.busy  = 1'b1;
            d.cnt   = 22'h000000;
          end
        end
      end

      HST_CONV: begin
        d.sclk = 1'b0;
        if (q.cnt >= 22'(OUT_EN_CYC) && q.sync) begin
          d.state   = HST_SHIFT;
          d.halfCnt = 4'h0;
          d.edgeCnt = 4'h0;
        end else if (q.cnt >= 22'(CONV_TMO_CYC)) begin
          d.state = HST_ACQ;
          d.csN   = 1'b1;
          d.cnt   = 22'h000000;
          d.timeoutPulse = 1'b1;
        end
      end

      HST_SHIFT: begin
        d.halfCnt = q.halfCnt + 4'h1;
        if (q.halfCnt == 4'(HALF_CYC - 1)) begin
          d.halfCnt = 4'h0;
          d.sclk    = ~q.sclk;
          if (!q.sclk) begin
            d.shift = {q.shift[11:0], q.sync};
          end else begin
            d.edgeCnt = q.edgeCnt + 4'h1;
            if (q.edgeCnt == 4'(FRAME_EDGES - 1)) begin
              d.state     = HST_STORE;
              d.csN       = 1'b1;
              d.pushValid = 1'b1;
              d.cnt       = 22'h000000;
            end
          end
        end
      end

      HST_STORE: begin
        if (q.pushValid && fifoReady) begin
          d.pushValid = 1'b0;
          d.frameErr  = ~q.shift[RES_W];
          d.state     = HST_ACQ;
        end
      end

      default: begin
        d.state = HST_ACQ;
      end
    endcase

    d.pdOe = (d.state == HST_DOWN) | useIntRef;
    d.pdO  = (d.state != HST_DOWN);
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      q <= HOST_RST;
    end else if (ce) begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------
  // result buffer
  // ---------------------------------------------------------------
  sas_fifo #(
    .WIDTH (RES_W),
    .DEPTH (FIFO_DEPTH)
  ) uFifo (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .ce       (ce),
    .inValid  (q.pushValid),
    .inReady  (fifoReady),
    .inData   (q.shift[RES_W-1:0]),
    .outValid (outValid),
    .outReady (outReady),
    .outData  (outData)
  );

  assign link.csN     = q.csN;
  assign link.sclk    = q.sclk;
  assign link.pdO     = q.pdO;
  assign link.pdOe    = q.pdOe;
  assign busy         = q.busy;
  assign linkReady    = q.linkReady;
  assign timeoutPulse = q.timeoutPulse;
  assign frameErr     = q.frameErr;
endmodule
`default_nettype wire

// file: rtl/sas_tail.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// file: verif/sas_link_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module sas_link_asserts import sas_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic csN,
  input wire logic sclk,
  input wire logic doutO,
  input wire logic doutOe,
  input wire logic pdO,
  input wire logic pdOe,
  input wire logic doutLevel
);
  // ------------------------------------------------------------
  // frame tracking
  // ------------------------------------------------------------
  // the device sees the wire through a 3-stage sync, hence the 3
  localparam int EOC_CYC = 3 + CONV_CYC;
  logic       conv;
  logic       eocSeen;
  logic [9:0] convCnt;
  logic [7:0] highCnt;
  logic [4:0] fallCnt;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      conv    <= 1'b0;
      eocSeen <= 1'b0;
      convCnt <= 10'h000;
      highCnt <= 8'h00;
      fallCnt <= 5'h00;
    end else begin
      conv    <= $fell(csN) | (conv & ~csN & ~$rose(doutO));
      eocSeen <= ~$fell(csN) & (eocSeen | (conv & $rose(doutO)));
      convCnt <= $fell(csN) ? 10'h001 :
                 (convCnt == 10'h3FF) ? convCnt : convCnt + 10'h001;
      highCnt <= ~csN ? 8'h00 :
                 (highCnt == 8'hFF) ? highCnt : highCnt + 8'h01;
      fallCnt <= $fell(csN) ? 5'h00 : fallCnt + {4'h0, $fell(sclk)};
    end
  end

  // ------------------------------------------------------------
  // wire rules
  // ------------------------------------------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  oe_off_idle_a: assert property (csN [*4] |-> !doutOe)
    else $error("data line driven while deselected");
  conv_low_a: assert property (
    $fell(csN) |-> ##3 (doutOe && !doutO))
    else $error("data line not low at conversion start");
  eoc_time_a: assert property (
    conv && $rose(doutO) |-> convCnt == EOC_CYC)
    else $error("end of conversion at wrong cycle");
  conv_bound_a: assert property (conv |-> convCnt <= EOC_CYC)
    else $error("conversion overran its time");
  sclk_quiet_a: assert property (conv |-> !sclk)
    else $error("serial clock active during conversion");
  shift_edge_a: assert property (
    doutOe && $past(doutOe) && !conv && $changed(doutO)
    |-> $past(sclk, 4) && !$past(sclk, 3))
    else $error("data changed without a clock fall");
  sclk_phase_a: assert property (
    $changed(sclk) |-> ##1 $stable(sclk) [*8] ##1 $stable(sclk))
    else $error("serial clock phase too short");
  idle_clock_a: assert property (csN |-> !sclk)
    else $error("serial clock high while deselected");
  acq_gap_a: assert property ($fell(csN) |-> highCnt >= ACQ_CYC)
    else $error("acquisition gap too short");
  frame_edges_a: assert property (
    $rose(csN) && eocSeen |-> (fallCnt + $fell(sclk)) >= FRAME_EDGES)
    else $error("frame ended with too few clock falls");
  eoc_flag_a: assert property (
    eocSeen && !csN && fallCnt == 5'h00 |-> doutLevel)
    else $error("end-of-conversion flag bit not high");
  shutdown_quiet_a: assert property (
    (pdOe && !pdO) [*4] |-> !doutOe)
    else $error("data line driven in shutdown");
  no_start_off_a: assert property (pdOe && !pdO |-> csN)
    else $error("conversion started in shutdown");
endmodule
`default_nettype wire

// file: verif/tb_sar_adc_serial_readout.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin \
  fail_count++; $display("BAD %s exp=%h got=%h", nm, ex, gt); end end
module tb_sar_adc_serial_readout import sas_pkg::*;;
  logic             clk_sys = 1'b0;
  logic             rst = 1'b1;
  logic             runEnable = 1'b0;
  logic             shutdownReq = 1'b0;
  logic             useIntRef = 1'b0;
  logic             outReady = 1'b0;
  logic [RES_W-1:0] analogA = 12'h000;
  logic [RES_W-1:0] analogB = 12'h000;
  logic [RES_W-1:0] outData;
  logic [RES_W-1:0] resB;
  logic             outValid;
  logic             frameErr;
  logic             shdnA;
  logic             irefA;
  logic             busyB;
  logic             shdnB;
  logic             awakeB;
  logic             srB;
  logic             cvB;
  logic             busyA;
  logic             readyA;
  logic             toA;
  logic             holdB;
  logic             rdB;
  int               rdCnt = 0;
  int               toCnt = 0;
  int               fail_count = 0;
  int               checks = 0;
  int               cyc = 0;
  int               csFalls = 0;
  int               errFrames = 0;
  int               cvCnt = 0;
  int               srCnt = 0;

  // ------------------------------------------------------------
  // two links: host against device, bench against device
  // ------------------------------------------------------------
  sas_link_if linkA ();
  sas_link_if linkB ();

  sas_host #(.PWRUP_WAIT(20)) sas_host_inst (
    .clk_sys, .rst, .ce(1'b1), .link(linkA.host), .runEnable,
    .shutdownReq, .useIntRef, .outData, .outValid, .outReady,
    .busy(busyA), .linkReady(readyA), .timeoutPulse(toA), .frameErr);
  sas_device sas_device_inst (
    .clk_sys, .rst, .ce(1'b1), .link(linkA.dev), .analogInput(analogA),
    .resultCode(), .resultValid(), .busy(), .holding(),
    .shutdown(shdnA), .internalRef(irefA), .awake(), .startRefused(),
    .clkViolation(), .readoutDone());
  sas_device sas_device_inst_b (
    .clk_sys, .rst, .ce(1'b1), .link(linkB.dev), .analogInput(analogB),
    .resultCode(resB), .resultValid(), .busy(busyB), .holding(holdB),
    .shutdown(shdnB), .internalRef(), .awake(awakeB),
    .startRefused(srB), .clkViolation(cvB), .readoutDone(rdB));
  sas_link_asserts sas_link_asserts_inst (
    .clk_sys, .rst, .csN(linkA.csN), .sclk(linkA.sclk),
    .doutO(linkA.doutO), .doutOe(linkA.doutOe), .pdO(linkA.pdO),
    .pdOe(linkA.pdOe), .doutLevel(linkA.doutLevel));

  always #5 clk_sys = ~clk_sys;
  always @(negedge linkA.csN) csFalls++;
  always @(posedge clk_sys) begin
    cyc++;
    if (frameErr === 1'b1) errFrames++;
    if (cvB === 1'b1) cvCnt++;
    if (srB === 1'b1) srCnt++;
    if (rdB === 1'b1) rdCnt++;
    if (toA === 1'b1) toCnt++;
    if (cyc == 40000) begin
      fail_count++;
      $display("BAD timeout exp=%0d got=%0d", 40000, cyc);
      report_and_stop();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic report_and_stop();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  // bench link clock: 80 ns period, edges on falling clock edges
  task automatic shift_b(output logic [14:0] bits);
    bits = '0;
    repeat (15) begin
      tick(4);
      linkB.sclk = 1'b1;
      bits = {bits[13:0], linkB.doutLevel};
      tick(4);
      linkB.sclk = 1'b0;
    end
  endtask

  task automatic t_direct_b();
    int          i;
    logic [14:0] bits;
    analogB = 12'h5A3;
    linkB.csN = 1'b0;
    for (i = 0; i < 1000 && linkB.doutO !== 1'b1; i++) begin
      tick(1);
      if (i == 4) begin
        `CHK("conv oe", 2'b01, {linkB.doutO, linkB.doutOe})
        analogB = 12'hFFF;
      end
    end
    `CHK("eoc time", 3 + CONV_CYC, i)
    `CHK("result", 12'h5A3, resB)
    shift_b(bits);
    `CHK("frame", {1'b1, 12'h5A3, 2'b00}, bits)
    `CHK("readout done", 1, rdCnt)
    linkB.csN = 1'b1;
    tick(5);
    `CHK("released", 1'b0, linkB.doutOe)
    tick(200);
  endtask

  task automatic t_fault_b();
    linkB.csN = 1'b0;
    tick(100);
    // clocked mid-conversion on purpose; must not disturb it
    linkB.sclk = 1'b1;
    tick(4);
    linkB.sclk = 1'b0;
    tick(20);
    `CHK("clock flagged", 1, cvCnt)
    `CHK("still busy", 1'b1, busyB)
    `CHK("holding", 1'b1, holdB)
    linkB.csN = 1'b1;
    tick(5);
    `CHK("abort oe", 1'b0, linkB.doutOe)
    `CHK("abort busy", 1'b0, busyB)
    tick(200);
    linkB.pdO = 1'b0;
    linkB.pdOe = 1'b1;
    tick(10);
    `CHK("off", 1'b1, shdnB)
    linkB.csN = 1'b0;
    tick(10);
    `CHK("off oe", 1'b0, linkB.doutOe)
    linkB.csN = 1'b1;
    linkB.pdOe = 1'b0;
    tick(10);
    `CHK("waking", 1'b0, awakeB)
    // a start inside the wake delay must be refused
    linkB.csN = 1'b0;
    tick(10);
    `CHK("refused", 1, srCnt)
    `CHK("refused oe", 1'b0, linkB.doutOe)
    linkB.csN = 1'b1;
    tick(WAKE_CYC);
    `CHK("awake", 1'b1, awakeB)
  endtask

  task automatic t_fill();
    `CHK("link ready", 1'b1, readyA)
    analogA = 12'hA5C;
    runEnable = 1'b1;
    for (int i = 0; i < 15000 && csFalls < 8; i++) tick(1);
    // last frame lands; a full buffer must then hold the host off
    tick(3000);
    `CHK("conversions", 8, csFalls)
    outReady = 1'b1;
    for (int i = 0; i < 8; i++) begin
      `CHK("fifo valid", 1'b1, outValid)
      `CHK("fifo data", 12'hA5C, outData)
      tick(1);
    end
    outReady = 1'b0;
    `CHK("fifo empty", 1'b0, outValid)
  endtask

  task automatic t_stream();
    analogA = 12'h801;
    outReady = 1'b1;
    @(negedge linkA.csN);
    tick(20);
    `CHK("host busy", 1'b1, busyA)
    analogA = 12'h3FF;
    for (int i = 0; i < 2000 && outValid !== 1'b1; i++) tick(1);
    `CHK("held sample", 12'h801, outData)
    tick(1);
    for (int i = 0; i < 2000 && outValid !== 1'b1; i++) tick(1);
    `CHK("next sample", 12'h3FF, outData)
  endtask

  task automatic t_power_down_n();
    int n;
    int i;
    runEnable = 1'b0;
    tick(1500);
    useIntRef = 1'b1;
    tick(10);
    `CHK("int ref", 1'b1, irefA)
    useIntRef = 1'b0;
    tick(10);
    `CHK("ext ref", 1'b0, irefA)
    shutdownReq = 1'b1;
    tick(10);
    `CHK("shutdown", 1'b1, shdnA)
    n = csFalls;
    shutdownReq = 1'b0;
    runEnable = 1'b1;
    for (i = 0; i < 2000 && csFalls == n; i++) tick(1);
    `CHK("wake wait", 1'b1, i >= WAKE_CYC)
  endtask

  initial begin
    linkB.csN = 1'b1;
    linkB.sclk = 1'b0;
    linkB.pdO = 1'b1;
    linkB.pdOe = 1'b0;
    tick(20);
    rst = 1'b0;
    tick(5);
    t_direct_b();
    t_fault_b();
    t_fill();
    t_stream();
    t_power_down_n();
    `CHK("bad frames", 0, errFrames)
    `CHK("timeouts", 0, toCnt)
    report_and_stop();
  end
endmodule
`default_nettype wire
